// ===== hdl/i2cmt_pkg.sv
// constants and types of the two-wire master start, restart and transmit sequencer
package i2cmt_pkg;
    // control two low field layout
    localparam int CTL_LOW_W = 5;
    localparam int CTL_SEN_POS = 0;
    localparam int CTL_RESTART_SEQ_ENABLE_POS = 1;
    localparam logic [4:0] CTL_RESET = 5'h00;
    // baud reload field widths
    localparam int RELOAD_W = 7;
    localparam int RS_RELOAD_W = 6;
    localparam logic [6:0] RELOAD_RESET = 7'h00;
    localparam int BYTE_W = 8;
    localparam logic [7:0] BUF_RESET = 8'h00;
    // bit counter values
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    // commands from the software side, one toggle each
    localparam int CMD_W = 3;
    localparam int CMD_START = 0;
    localparam int CMD_RESTART = 1;
    localparam int CMD_TX = 2;
    // events from the link side, one toggle each
    localparam int EV_W = 6;
    localparam int EV_START_DET = 0;
    localparam int EV_START_DONE = 1;
    localparam int EV_RS_DONE = 2;
    localparam int EV_BF_CLR = 3;
    localparam int EV_BYTE_DONE = 4;
    localparam int EV_BCL = 5;
    // timing
    localparam int SYS_CLK_NS = 40;
    localparam int INSTR_CYCLE_NS = 64;
    localparam int REWRITE_WIN_NS = 2 * INSTR_CYCLE_NS;
    localparam logic [1:0] REWRITE_CYC = 2'(REWRITE_WIN_NS / SYS_CLK_NS);
    // link sequencer states
    typedef enum logic [3:0] {
        L_IDLE,
        L_ST_WAIT,
        L_ST_HOLD,
        L_RS_SCL_LOW,
        L_RS_SDA_HI,
        L_RS_SCL_REL,
        L_RS_HIGH,
        L_RS_SDA_LOW,
        L_TX_LOW,
        L_TX_REL,
        L_TX_HIGH
    } i2cmt_state_type;
endpackage : i2cmt_pkg

// ===== hdl/i2cmt_master.sv
// two-wire master sequencer: start, repeated start and byte transmit
`timescale 1ns/10ps
module i2cmt_master
    import i2cmt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic ctl_wr,
    input wire logic [CTL_LOW_W-1:0] ctl_wdata,
    input wire logic reload_wr,
    input wire logic [RELOAD_W-1:0] reload_wdata,
    input wire logic buf_wr,
    input wire logic [BYTE_W-1:0] buf_wdata,
    input wire logic write_collision_flag_clr,
    input wire logic bcl_clr,
    input wire logic pif_clr,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    output logic [CTL_LOW_W-1:0] port_control_low,
    output logic start_seq_enable,
    output logic restart_seq_enable,
    output logic [RELOAD_W-1:0] baud_reload_reg,
    output logic [BYTE_W-1:0] transmit_buffer,
    output logic buffer_full_flag,
    output logic write_collision_flag,
    output logic collision_flag,
    output logic port_interrupt_flag,
    output logic start_detected,
    output logic ack_status_bit,
    output logic busy
);

    // sticky flag update, a set wins over a clear
    function automatic logic flag_nxt(input logic cur, input logic set, input logic clr);
        flag_nxt = set | (cur & ~clr);
    endfunction : flag_nxt

    // ---------------- software side, sys_clk ----------------
    logic [CTL_LOW_W-1:0] ctl_r;
    logic [RELOAD_W-1:0] reload_r;
    logic [BYTE_W-1:0] buf_r;
    logic busy_r;
    logic bf_r;
    logic write_collision_flag_r;
    logic bcl_r;
    logic pif_r;
    logic sdet_r;
    logic ackst_r;
    logic [1:0] win_r;
    logic [CMD_W-1:0] cmd_tog_r;
    logic [EV_W-1:0] ev_meta_r;
    logic [EV_W-1:0] ev_sync_r;
    logic [EV_W-1:0] ev_seen_r;
    logic ack_meta_r;
    logic ack_sync_r;
    // link side flops that the synchronisers above read
    logic ack_r;
    logic [EV_W-1:0] ev_tog_r;

    wire [EV_W-1:0] ev_hit = ev_sync_r ^ ev_seen_r;
    wire ev_bcl = ev_hit[EV_BCL];
    wire ev_done = ev_hit[EV_START_DONE] | ev_hit[EV_RS_DONE] | ev_hit[EV_BYTE_DONE] | ev_bcl;
    wire ctl_take = ctl_wr & ~busy_r;
    wire go_start = ctl_take & ctl_wdata[CTL_SEN_POS];
    wire go_rs = ctl_take & ~ctl_wdata[CTL_SEN_POS] & ctl_wdata[CTL_RESTART_SEQ_ENABLE_POS];
    wire buf_take = buf_wr & ~busy_r;
    // busy buffer write is a collision
    wire buf_coll = buf_wr & busy_r;
    wire buf_upd = buf_take | (buf_coll & (win_r != 2'h0));
    wire [CTL_LOW_W-1:0] ctl_clr_mask = {{(CTL_LOW_W-2){1'b0}},
        ev_hit[EV_RS_DONE] | ev_bcl, ev_hit[EV_START_DONE] | ev_bcl};
    wire [CTL_LOW_W-1:0] ctl_nxt = ctl_take ? ctl_wdata : (ctl_r & ~ctl_clr_mask);
    wire [CMD_W-1:0] cmd_flip = {buf_take, go_rs, go_start};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ev_meta_r <= '0;
            ev_sync_r <= '0;
            ev_seen_r <= '0;
            ack_meta_r <= 1'b0;
            ack_sync_r <= 1'b0;
        end else begin
            ev_meta_r <= ev_tog_r;
            ev_sync_r <= ev_meta_r;
            ev_seen_r <= ev_sync_r;
            ack_meta_r <= ack_r;
            ack_sync_r <= ack_meta_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctl_r <= CTL_RESET;
            reload_r <= RELOAD_RESET;
            buf_r <= BUF_RESET;
            cmd_tog_r <= '0;
        end else begin
            // hardware clears start enable at completion
            ctl_r <= ctl_nxt;
            // reload held steady while a sequence runs
            if (reload_wr && !busy_r) begin
                reload_r <= reload_wdata;
            end
            if (buf_upd) begin
                buf_r <= buf_wdata;
            end
            cmd_tog_r <= cmd_tog_r ^ cmd_flip;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
            win_r <= 2'h0;
        end else begin
            busy_r <= (busy_r & ~ev_done) | go_start | go_rs | buf_take;
            if (buf_take) begin
                win_r <= REWRITE_CYC;
            end else if (win_r != 2'h0) begin
                win_r <= win_r - 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bf_r <= 1'b0;
            write_collision_flag_r <= 1'b0;
            bcl_r <= 1'b0;
            pif_r <= 1'b0;
            sdet_r <= 1'b0;
            ackst_r <= 1'b0;
        end else begin
            // full flag set by accepted write
            bf_r <= flag_nxt(bf_r, buf_take, ev_hit[EV_BF_CLR] | ev_bcl);
            write_collision_flag_r <= flag_nxt(write_collision_flag_r, buf_coll, write_collision_flag_clr);
            bcl_r <= flag_nxt(bcl_r, ev_bcl, bcl_clr);
            pif_r <= flag_nxt(pif_r, ev_hit[EV_START_DONE] | ev_hit[EV_RS_DONE]
                | ev_hit[EV_BYTE_DONE], pif_clr);
            sdet_r <= flag_nxt(sdet_r, ev_hit[EV_START_DET], ev_bcl);
            if (ev_hit[EV_BYTE_DONE]) begin
                ackst_r <= ack_sync_r;
            end
        end
    end

    assign port_control_low = ctl_r;
    assign start_seq_enable = ctl_r[CTL_SEN_POS];
    assign restart_seq_enable = ctl_r[CTL_RESTART_SEQ_ENABLE_POS];
    assign baud_reload_reg = reload_r;
    assign transmit_buffer = buf_r;
    assign buffer_full_flag = bf_r;
    assign write_collision_flag = write_collision_flag_r;
    assign collision_flag = bcl_r;
    assign port_interrupt_flag = pif_r;
    assign start_detected = sdet_r;
    assign ack_status_bit = ackst_r;
    assign busy = busy_r;

    // ---------------- link side, link_clk ----------------
    logic rst_meta_r;
    logic rst_l_r;
    logic scl_meta_r;
    logic scl_s_r;
    logic sda_meta_r;
    logic sda_s_r;
    logic sda_prev_r;
    logic [CMD_W-1:0] cmd_meta_r;
    logic [CMD_W-1:0] cmd_sync_r;
    logic [CMD_W-1:0] cmd_seen_r;
    i2cmt_state_type state_r;
    i2cmt_state_type state_nxt;
    logic [RELOAD_W-1:0] brg_r;
    logic [BYTE_W-1:0] shift_r;
    logic [BYTE_W-1:0] shift_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic scl_oe_r;
    logic scl_oe_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic ack_nxt;
    logic [EV_W-1:0] ev_fire;
    logic brg_load;
    logic [RELOAD_W-1:0] brg_val;

    wire [CMD_W-1:0] cmd_ev = cmd_sync_r ^ cmd_seen_r;
    wire brg_zero = (brg_r == RELOAD_RESET);
    wire lines_high = scl_s_r & sda_s_r;
    wire line_start = sda_prev_r & ~sda_s_r & scl_s_r;
    wire [RELOAD_W-1:0] rs_reload = {1'b0, reload_r[RS_RELOAD_W-1:0]};

    always_ff @(posedge link_clk) begin
        rst_meta_r <= sys_rst;
        rst_l_r <= rst_meta_r;
    end

    always_ff @(posedge link_clk) begin
        if (rst_l_r) begin
            scl_meta_r <= 1'b1;
            scl_s_r <= 1'b1;
            sda_meta_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_prev_r <= 1'b1;
            cmd_meta_r <= '0;
            cmd_sync_r <= '0;
            cmd_seen_r <= '0;
        end else begin
            scl_meta_r <= scl_in;
            scl_s_r <= scl_meta_r;
            sda_meta_r <= sda_in;
            sda_s_r <= sda_meta_r;
            sda_prev_r <= sda_s_r;
            cmd_meta_r <= cmd_tog_r;
            cmd_sync_r <= cmd_meta_r;
            cmd_seen_r <= cmd_sync_r;
        end
    end

    always_comb begin
        state_nxt = state_r;
        brg_load = 1'b0;
        brg_val = reload_r;
        scl_oe_nxt = scl_oe_r;
        sda_oe_nxt = sda_oe_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        ack_nxt = ack_r;
        ev_fire = '0;
        // start flagged as soon as seen on lines
        ev_fire[EV_START_DET] = line_start;
        unique case (state_r)
            L_IDLE: begin
                if (cmd_ev[CMD_START]) begin
                    if (lines_high) begin
                        brg_load = 1'b1;
                        state_nxt = L_ST_WAIT;
                    end else begin
                        ev_fire[EV_BCL] = 1'b1;
                        scl_oe_nxt = 1'b0;
                        sda_oe_nxt = 1'b0;
                    end
                end else if (cmd_ev[CMD_RESTART]) begin
                    scl_oe_nxt = 1'b1;
                    state_nxt = L_RS_SCL_LOW;
                end else if (cmd_ev[CMD_TX]) begin
                    scl_oe_nxt = 1'b1;
                    shift_nxt = buf_r;
                    cnt_nxt = 4'h0;
                    brg_load = 1'b1;
                    state_nxt = L_TX_LOW;
                end
            end
            L_ST_WAIT: begin
                if (!lines_high) begin
                    ev_fire[EV_BCL] = 1'b1;
                    state_nxt = L_IDLE;
                end else if (brg_zero) begin
                    // data driven low under high clock
                    sda_oe_nxt = 1'b1;
                    brg_load = 1'b1;
                    state_nxt = L_ST_HOLD;
                end
            end
            L_ST_HOLD: begin
                if (brg_zero) begin
                    ev_fire[EV_START_DONE] = 1'b1;
                    state_nxt = L_IDLE;
                end
            end
            L_RS_SCL_LOW: begin
                if (!scl_s_r) begin
                    brg_load = 1'b1;
                    brg_val = rs_reload;
                    sda_oe_nxt = 1'b0;
                    state_nxt = L_RS_SDA_HI;
                end
            end
            L_RS_SDA_HI: begin
                if (brg_zero) begin
                    if (sda_s_r) begin
                        scl_oe_nxt = 1'b0;
                        state_nxt = L_RS_SCL_REL;
                    end else begin
                        ev_fire[EV_BCL] = 1'b1;
                        scl_oe_nxt = 1'b0;
                        state_nxt = L_IDLE;
                    end
                end
            end
            L_RS_SCL_REL: begin
                if (scl_s_r) begin
                    if (!sda_s_r) begin
                        ev_fire[EV_BCL] = 1'b1;
                        state_nxt = L_IDLE;
                    end else begin
                        brg_load = 1'b1;
                        state_nxt = L_RS_HIGH;
                    end
                end
            end
            L_RS_HIGH: begin
                if (!lines_high) begin
                    ev_fire[EV_BCL] = 1'b1;
                    state_nxt = L_IDLE;
                end else if (brg_zero) begin
                    sda_oe_nxt = 1'b1;
                    brg_load = 1'b1;
                    state_nxt = L_RS_SDA_LOW;
                end
            end
            L_RS_SDA_LOW: begin
                if (brg_zero) begin
                    ev_fire[EV_RS_DONE] = 1'b1;
                    state_nxt = L_IDLE;
                end
            end
            L_TX_LOW: begin
                sda_oe_nxt = (cnt_r == ACK_BIT) ? 1'b0 : ~shift_r[BYTE_W-1];
                if (brg_zero) begin
                    scl_oe_nxt = 1'b0;
                    state_nxt = L_TX_REL;
                end
            end
            L_TX_REL: begin
                if (scl_s_r) begin
                    // high time counted from sampled high
                    brg_load = 1'b1;
                    state_nxt = L_TX_HIGH;
                end
            end
            L_TX_HIGH: begin
                if (cnt_r == ACK_BIT) begin
                    ack_nxt = sda_s_r;
                end
                if (brg_zero) begin
                    scl_oe_nxt = 1'b1;
                    if (cnt_r == ACK_BIT) begin
                        ack_nxt = sda_s_r;
                        // interrupt, clock held low, data kept
                        ev_fire[EV_BYTE_DONE] = 1'b1;
                        state_nxt = L_IDLE;
                    end else begin
                        shift_nxt = {shift_r[BYTE_W-2:0], 1'b0};
                        cnt_nxt = cnt_r + 4'h1;
                        brg_load = 1'b1;
                        state_nxt = L_TX_LOW;
                        if (cnt_r == LAST_DATA_BIT) begin
                            // eighth fall clears full, frees data
                            ev_fire[EV_BF_CLR] = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (rst_l_r) begin
            state_r <= L_IDLE;
            brg_r <= RELOAD_RESET;
        end else begin
            state_r <= state_nxt;
            // count down to zero, then stop
            if (brg_load) begin
                brg_r <= brg_val;
            end else if (!brg_zero) begin
                brg_r <= brg_r - 7'h01;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (rst_l_r) begin
            shift_r <= BUF_RESET;
            cnt_r <= 4'h0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            ack_r <= 1'b0;
            ev_tog_r <= '0;
        end else begin
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            scl_oe_r <= scl_oe_nxt;
            sda_oe_r <= sda_oe_nxt;
            ack_r <= ack_nxt;
            ev_tog_r <= ev_tog_r ^ ev_fire;
        end
    end

    // open-drain pins only ever drive low
    always_ff @(posedge link_clk) begin
        scl_out <= 1'b0;
        sda_out <= 1'b0;
    end

    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;

endmodule : i2cmt_master

// ===== sim/i2cmt_properties.sv
// port assertions of the two-wire master sequencer
`timescale 1ns/10ps
module i2cmt_properties
    import i2cmt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic ctl_wr,
    input wire logic buf_wr,
    input wire logic [BYTE_W-1:0] buf_wdata,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic [CTL_LOW_W-1:0] port_control_low,
    input wire logic start_seq_enable,
    input wire logic restart_seq_enable,
    input wire logic [BYTE_W-1:0] transmit_buffer,
    input wire logic buffer_full_flag,
    input wire logic write_collision_flag,
    input wire logic collision_flag,
    input wire logic port_interrupt_flag,
    input wire logic busy
);
    sequence s_buf_accept;
        !busy && buf_wr && !ctl_wr;
    endsequence
    sequence s_seq_write;
        busy && (start_seq_enable || restart_seq_enable) && buf_wr;
    endsequence
    a_ctl_field_locked: assert property (
        @(posedge sys_clk) disable iff (sys_rst) busy && ctl_wr |=> $stable(port_control_low[4:2]))
        else $error("control bits changed while busy");
    a_rs_ignored_busy: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        busy && ctl_wr && !restart_seq_enable |=> !restart_seq_enable)
        else $error("restart enable taken while busy");
    a_buf_kept_seq: assert property (
        @(posedge sys_clk) disable iff (sys_rst) s_seq_write |=> $stable(transmit_buffer))
        else $error("buffer written during start sequence");
    a_write_collision_flag_on_busy: assert property (
        @(posedge sys_clk) disable iff (sys_rst) busy && buf_wr |=> write_collision_flag)
        else $error("write collision not flagged");
    a_full_on_write: assert property (
        @(posedge sys_clk) disable iff (sys_rst) s_buf_accept
        |=> buffer_full_flag && busy && transmit_buffer == $past(buf_wdata))
        else $error("accepted write not taken");
    a_start_ends_irq: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(start_seq_enable) |-> ##[0:1] (port_interrupt_flag || collision_flag))
        else $error("start ended without flag");
    a_rs_irq_late: assert property (
        @(posedge sys_clk) disable iff (sys_rst) restart_seq_enable && !port_interrupt_flag
        |=> !port_interrupt_flag || !restart_seq_enable)
        else $error("restart interrupt too early");
    a_bcl_aborts: assert property (
        @(posedge sys_clk) disable iff (sys_rst) $rose(collision_flag)
        |-> ##[0:2] (!start_seq_enable && !restart_seq_enable && !busy))
        else $error("collision did not abort");
    a_start_sda_first: assert property (
        @(posedge link_clk) disable iff (sys_rst) start_seq_enable && $rose(sda_oe) |-> !scl_oe)
        else $error("start drove data with clock low");
    a_sda_stable_high: assert property (
        @(posedge link_clk) disable iff (sys_rst) !scl_oe && !$past(scl_oe)
        && !start_seq_enable && !restart_seq_enable |-> $stable(sda_oe))
        else $error("data moved while clock high");
endmodule : i2cmt_properties
bind i2cmt_master i2cmt_properties u_props (.sys_clk, .sys_rst, .link_clk, .ctl_wr, .buf_wr,
    .buf_wdata, .scl_oe, .sda_oe, .port_control_low, .start_seq_enable, .restart_seq_enable,
    .transmit_buffer, .buffer_full_flag, .write_collision_flag, .collision_flag,
    .port_interrupt_flag, .busy);

// ===== sim/i2cmt_slave_model.sv
// slave on the two wires: pull-ups, acknowledge, clock stretch
`timescale 1ns/10ps
module i2cmt_slave_model (
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic ack_en,
    input wire logic stretch,
    input wire logic sda_hold,
    output wire logic scl_line,
    output wire logic sda_line,
    output logic [7:0] rx_byte
);
    logic ack_drive = 1'b0;
    int bit_cnt = 0;
    // released lines float high through the pull-ups
    assign scl_line = ~(scl_oe | stretch);
    assign sda_line = ~(sda_oe | sda_hold | ack_drive);
    initial rx_byte = 8'h00;
    always @(negedge sda_line) begin
        if (scl_line) begin
            bit_cnt = 0;
        end
    end
    always @(posedge scl_line) begin
        if (bit_cnt < 8) begin
            rx_byte = {rx_byte[6:0], sda_line};
        end
        bit_cnt = bit_cnt + 1;
    end
    // acknowledge held low through the ninth bit
    always @(negedge scl_line) begin
        ack_drive = ack_en && bit_cnt == 8;
        if (bit_cnt >= 9) begin
            bit_cnt = 0;
        end
    end
endmodule : i2cmt_slave_model

// ===== sim/i2cmt_master_bench.sv
// self-checking bench of the two-wire master sequencer
`timescale 1ns/10ps
module i2cmt_master_bench;
    import i2cmt_pkg::*;
    localparam int WR_CTL = 0;
    localparam int WR_BUF = 1;
    localparam int WR_RLD = 2;
    localparam int WR_CLR = 3;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ctl_wr = 1'b0;
    logic reload_wr = 1'b0;
    logic buf_wr = 1'b0;
    logic write_collision_flag_clr = 1'b0;
    logic bcl_clr = 1'b0;
    logic pif_clr = 1'b0;
    logic ack_en = 1'b1;
    logic stretch = 1'b0;
    logic sda_hold = 1'b0;
    logic [CTL_LOW_W-1:0] ctl_wdata = 5'h00;
    logic [RELOAD_W-1:0] reload_wdata = 7'h00;
    logic [BYTE_W-1:0] buf_wdata = 8'h00;
    wire scl_line, sda_line, scl_oe, sda_oe, start_seq_enable, restart_seq_enable;
    wire buffer_full_flag, write_collision_flag, collision_flag, port_interrupt_flag;
    wire start_detected, ack_status_bit, busy;
    wire [CTL_LOW_W-1:0] port_control_low;
    wire [RELOAD_W-1:0] baud_reload_reg;
    wire [BYTE_W-1:0] transmit_buffer, rx_byte;
    int err_count = 0;
    int samples_checked = 0;
    always #20 sys_clk = ~sys_clk;
    always #16 link_clk = ~link_clk;
    i2cmt_master dut (.sys_clk, .sys_rst, .link_clk, .ctl_wr, .ctl_wdata, .reload_wr,
        .reload_wdata, .buf_wr, .buf_wdata, .write_collision_flag_clr, .bcl_clr, .pif_clr, .scl_in(scl_line),
        .sda_in(sda_line), .scl_out(), .scl_oe, .sda_out(), .sda_oe, .port_control_low,
        .start_seq_enable, .restart_seq_enable, .baud_reload_reg, .transmit_buffer,
        .buffer_full_flag, .write_collision_flag, .collision_flag, .port_interrupt_flag,
        .start_detected, .ack_status_bit, .busy);
    i2cmt_slave_model peer (.scl_oe, .sda_oe, .ack_en, .stretch, .sda_hold, .scl_line,
        .sda_line, .rx_byte);
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : tick
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            tick(1);
            n++;
        end
        if (n >= 3000) begin
            err_count++;
            $display("MISMATCH busy expected 0 seen 1");
            print_verdict();
        end
    endtask : wait_idle
    task automatic put(input int kind, input logic [7:0] d);
        ctl_wdata = d[4:0];
        reload_wdata = d[6:0];
        buf_wdata = d;
        ctl_wr = (kind == WR_CTL);
        buf_wr = (kind == WR_BUF);
        reload_wr = (kind == WR_RLD);
        {write_collision_flag_clr, bcl_clr, pif_clr} = {3{kind == WR_CLR}};
        tick(1);
        {ctl_wr, buf_wr, reload_wr, write_collision_flag_clr, bcl_clr, pif_clr} = 6'h00;
        tick(1);
    endtask : put
    task automatic t_collide(input logic [4:0] cmd);
        sda_hold = 1'b1;
        put(WR_CTL, {3'h0, cmd});
        wait_idle();
        chk("collision", 8'h01, collision_flag);
        chk("enables", 8'h00, port_control_low[1:0]);
        chk("sda oe", 8'h00, sda_oe);
        chk("scl oe", 8'h00, scl_oe);
        sda_hold = 1'b0;
        put(WR_CLR, 8'h00);
        chk("collision clear", 8'h00, collision_flag);
    endtask : t_collide
    task automatic t_start;
        put(WR_CTL, 8'h01);
        chk("start enable", 8'h01, start_seq_enable);
        put(WR_BUF, 8'h3C);
        chk("write_collision_flag in start", 8'h01, write_collision_flag);
        chk("buffer in start", 8'h00, transmit_buffer);
        put(WR_CTL, 8'h1E);
        chk("locked control", 8'h01, port_control_low);
        wait_idle();
        chk("start enable off", 8'h00, start_seq_enable);
        chk("start seen", 8'h01, start_detected);
        chk("sda held", 8'h01, sda_oe);
        chk("scl free", 8'h00, scl_oe);
        chk("start irq", 8'h01, port_interrupt_flag);
        put(WR_CLR, 8'h00);
    endtask : t_start
    task automatic t_byte(input logic [7:0] d, input logic ack);
        ack_en = ack;
        put(WR_BUF, d);
        chk("full flag", 8'h01, buffer_full_flag);
        chk("buffer", d, transmit_buffer);
        chk("write_collision_flag after write", 8'h00, write_collision_flag);
        tick(2);
        put(WR_CTL, 8'h02);
        chk("restart ignored", 8'h00, restart_seq_enable);
        put(WR_BUF, ~d);
        chk("late rewrite write_collision_flag", 8'h01, write_collision_flag);
        chk("late rewrite kept", d, transmit_buffer);
        stretch = 1'b1;
        tick(40);
        stretch = 1'b0;
        wait_idle();
        chk("byte on wire", d, rx_byte);
        chk("ack status", {7'h00, ~ack}, ack_status_bit);
        chk("full cleared", 8'h00, buffer_full_flag);
        chk("byte irq", 8'h01, port_interrupt_flag);
        chk("scl held", 8'h01, scl_oe);
        put(WR_CLR, 8'h00);
    endtask : t_byte
    task automatic t_restart(input logic [7:0] prev);
        put(WR_CTL, 8'h02);
        chk("restart enable", 8'h01, restart_seq_enable);
        put(WR_BUF, 8'h55);
        chk("write_collision_flag in restart", 8'h01, write_collision_flag);
        chk("buffer in restart", prev, transmit_buffer);
        put(WR_CTL, 8'h01);
        chk("locked in restart", 8'h02, port_control_low);
        wait_idle();
        chk("restart enable off", 8'h00, restart_seq_enable);
        chk("restart irq", 8'h01, port_interrupt_flag);
        chk("sda low", 8'h01, sda_oe);
        chk("scl free", 8'h00, scl_oe);
        chk("start seen", 8'h01, start_detected);
        chk("no collision", 8'h00, collision_flag);
        put(WR_CLR, 8'h00);
    endtask : t_restart
    task automatic t_rewrite;
        put(WR_BUF, 8'h0F);
        put(WR_BUF, 8'hF0);
        chk("early rewrite write_collision_flag", 8'h01, write_collision_flag);
        chk("early rewrite lands", 8'hF0, transmit_buffer);
        wait_idle();
        put(WR_CLR, 8'h00);
    endtask : t_rewrite
    initial begin
        tick(3);
        sys_rst = 1'b0;
        tick(4);
        chk("reset control", 8'h00, port_control_low);
        chk("reset pins", 8'h00, {scl_oe, sda_oe, busy, collision_flag});
        put(WR_RLD, 8'h04);
        chk("reload", 8'h04, baud_reload_reg);
        t_collide(5'h01);
        t_start();
        t_byte(8'hA5, 1'b1);
        t_byte(8'h5A, 1'b0);
        t_collide(5'h02);
        t_restart(8'h5A);
        t_byte(8'hC3, 1'b1);
        t_rewrite();
        print_verdict();
    end
endmodule : i2cmt_master_bench
